// ### hw/ccd_pkg.sv
// ccd_pkg: constants and carrier types of the command card slot decoder.
// assumes a single 25 MHz clock and a classic Wishbone register bus.
package ccd_pkg;

  // clock rate and input filter time
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned DEB_TIME_US = 1000;         // 1 ms
  // least time, rounded up to whole cycles
  localparam int unsigned DEB_CYCLES  =
    (CLK_HZ / 1000 * DEB_TIME_US + 999) / 1000;

  // number of binary inputs and command outputs
  localparam int N_IN  = 4;
  localparam int N_SIG = 8;

  // register byte offsets
  localparam logic [7:0] REG_CTRL  = 8'h00;  // test mode control
  localparam logic [7:0] REG_CMD   = 8'h04;  // command relay data
  localparam logic [7:0] REG_INPUT = 8'h08;  // card input register
  localparam logic [7:0] REG_STAT  = 8'h0C;  // sticky change flags
  localparam logic [7:0] REG_MASK  = 8'h10;  // interrupt mask
  localparam logic [7:0] REG_SIG   = 8'h14;  // signaling relay data

  // field positions
  localparam int CTRL_TEST_BIT   = 0;
  localparam int INPUT_STRAP_BIT = 4;
  localparam int INPUT_GEN_BIT   = 5;

  // reset values
  localparam logic [3:0] CMD_RST  = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [7:0] SIG_RST  = 8'h00;

  // slot lines of the internal card bus, all active low
  typedef struct packed {
    logic slot_strobe_n;
    logic slot_code_line_one_n;
    logic slot_code_line_two_n;
  } ccd_slot_t;

  // every pin that must be synchronised
  typedef struct packed {
    logic            relay_coil_supply;
    logic            strap;
    logic            host_generation_switch;
    logic [1:0]      address_dip_switch;
    logic [N_IN-1:0] test_input_switches;
    logic [N_IN-1:0] bin;
    ccd_slot_t       slot;
  } ccd_pins_t;

  // bus answer state
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } ccd_bus_st_t;

endpackage : ccd_pkg

// ### hw/ccd_slot_decoder.sv
// ccd_slot_decoder: compares the host slot code with the local switches.
// assumes synchronised inputs; purely combinational.
`timescale 1ns/1ps
module ccd_slot_decoder (
  input  wire ccd_pkg::ccd_slot_t slot_i,       // host slot lines
  input  wire logic [1:0]         addr_sw_i,    // 1 = switch on
  output logic                    selected_o,   // card addressed
  output logic                    bcast_rst_o   // reset all cards
);

  logic [1:0] local_slot;   // 0..3 = slot one..four
  logic [1:0] host_slot;    // slot requested by host

  // decode both codes and compare
  always_comb begin
    unique case (addr_sw_i)
      2'b00:   local_slot = 2'h0;
      2'b01:   local_slot = 2'h1;  // first on
      2'b10:   local_slot = 2'h2;  // second on
      default: local_slot = 2'h3;  // both on
    endcase
    unique case ({slot_i.slot_code_line_one_n, slot_i.slot_code_line_two_n})
      2'b01:   host_slot = 2'h0;
      2'b10:   host_slot = 2'h1;
      2'b11:   host_slot = 2'h2;
      default: host_slot = 2'h3;
    endcase
    selected_o  = !slot_i.slot_strobe_n && (host_slot == local_slot);
    bcast_rst_o = slot_i.slot_strobe_n && !slot_i.slot_code_line_one_n
                  && !slot_i.slot_code_line_two_n;
  end

endmodule : ccd_slot_decoder

// ### hw/ccd_input_filter.sv
// ccd_input_filter: one binary input, accepted after a stable period.
// assumes a synchronised input on the same clock.
`timescale 1ns/1ps
module ccd_input_filter #(
  parameter int unsigned DEB   = ccd_pkg::DEB_CYCLES,
  parameter int          CNT_W = 16
) (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic clr_i,     // broadcast reset
  input  wire logic raw_i,     // synchronised level
  output logic      stable_o   // filtered level
);

  // all state of the filter
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             stable;
  } ccd_filt_t;

  ccd_filt_t st, next_st;

  // refuse counts the counter cannot hold
  if (DEB < 1 || DEB > (2**CNT_W - 1)) begin : g_chk
    $error("ccd_input_filter: DEB out of range");
  end

  // count while the input differs, take it after DEB cycles
  always_comb begin
    next_st = st;
    if (clr_i) begin
      next_st = '0;
    end else if (raw_i == st.stable) begin
      next_st.cnt = '0;
    end else if (st.cnt == CNT_W'(DEB - 1)) begin
      next_st.cnt    = '0;
      next_st.stable = raw_i;
    end else begin
      next_st.cnt = st.cnt + CNT_W'(1);
    end
  end

  // state register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign stable_o = st.stable;

endmodule : ccd_input_filter

// ### hw/ccd_card_controller.sv
// ccd_card_controller: command card with slot decoder, inputs and relays.
// assumes a classic Wishbone host and asynchronous pins on the card.
// assumes too that the host leaves one idle cycle after every ack.
//
// Contract
// - select only when host slot matches
// - strobe high, codes low resets all
// - strobe low, codes pick slot one..four
// - two switches give local slot address
// - identity from switches, not from position
// - third switch picks legacy or current host
// - input change raises host interrupt
// - relays follow host written command data
// - test mode: inputs off until switch rises
// - red per active output, green per input
// - signaling card: relay per associated command
// - input must stay one millisecond first
// - input register shows board variant strap
//
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module ccd_card_controller #(
  parameter int unsigned DEB_CYCLES = ccd_pkg::DEB_CYCLES,
  parameter int          DEB_W      = 16
) (
  input  wire logic               mclk_i,
  input  wire logic               rst_i,
  // classic Wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  output logic                    data_oe_n_o,
  // card pins
  input  wire ccd_pkg::ccd_slot_t slot_i,
  input  wire logic [2:0]         address_dip_switch_i,
  input  wire logic [3:0]         test_input_switches_i,
  input  wire logic [3:0]         bin_i,
  input  wire logic               variant_strap_i,
  input  wire logic               relay_coil_supply_i,
  // outputs
  output logic                    irq_o,
  output logic      [7:0]         relay_o,
  output logic      [3:0]         red_led_o,
  output logic      [3:0]         green_led_o,
  output logic                    test_led_o,
  output logic                    legacy_host_o,
  output logic                    card_selected_o
);

  localparam int N = ccd_pkg::N_IN;
  // edges after reset before the second sync stage holds pin values
  localparam logic [1:0] SYNC_FILL = 2'h2;

  // refuse an input count that the relay and led mapping cannot serve
  if (N != 4 || ccd_pkg::N_SIG != 2 * N) begin : g_chk_n
    $error("ccd_card_controller: four inputs and eight relays expected");
  end

  // refuse a filter time the counter cannot hold
  if (DEB_CYCLES < 1 || DEB_CYCLES > (2**DEB_W - 1)) begin : g_chk
    $error("ccd_card_controller: DEB_CYCLES out of range");
  end

  // all state of the controller
  // one struct, so reset and the next value cover every flop
  typedef struct packed {
    ccd_pkg::ccd_pins_t   s1;        // first sync stage
    ccd_pkg::ccd_pins_t   s2;        // second sync stage
    logic                 strap;     // caught variant strap
    logic                 strap_ok;  // strap has been caught
    logic [1:0]           fill;      // edges since reset, stops at two
    logic                 test_mode; // test mode active
    logic [N-1:0]         tin;       // test input states
    logic [N-1:0]         seen_off;  // switch seen off in test
    logic [N-1:0]         prev_in;   // last reported inputs
    logic [N-1:0]         cmd;       // command relay data
    logic [7:0]           sig;       // associated card data
    logic [N-1:0]         stat;      // sticky change flags
    logic [N-1:0]         mask;      // interrupt mask
    ccd_pkg::ccd_bus_st_t bus;       // bus answer state
    logic                 drive;     // data lines driven
    logic [31:0]          rdata;     // read data
    logic                 irq;       // interrupt level
    logic [7:0]           relay;     // relay drive
    logic [N-1:0]         green;     // green indicators
  } ccd_state_t;

  ccd_state_t st, next_st;

  ccd_pkg::ccd_pins_t pins;       // raw pins gathered
  logic [N-1:0]       filt;       // filtered binary inputs
  logic               selected;   // slot matched
  logic               bcast;      // broadcast reset seen
  logic [N-1:0]       rep_in;     // inputs as reported
  logic               req;        // bus request to this card
  logic               wr_ok;      // write on byte lane 0
  logic [31:0]        rd_mux;     // addressed register value

  // gather pins into one bundle for the synchroniser
  // nothing but the second stage of each pin is read by logic
  always_comb begin
    pins.relay_coil_supply      = relay_coil_supply_i;
    pins.strap                  = variant_strap_i;
    pins.host_generation_switch = address_dip_switch_i[2];
    pins.address_dip_switch     = address_dip_switch_i[1:0];
    pins.test_input_switches    = test_input_switches_i;
    pins.bin                    = bin_i;
    pins.slot                   = slot_i;
  end

  // slot decoder on the synchronised lines
  // select follows the lines two edges late, never a half-settled code
  ccd_slot_decoder u_dec (
    .slot_i      (st.s2.slot),
    .addr_sw_i   (st.s2.address_dip_switch),
    .selected_o  (selected),
    .bcast_rst_o (bcast)
  );

  // one filter per binary input
  // each filter also clears while the broadcast reset code stands
  for (genvar i = 0; i < N; i++) begin : g_filt
    ccd_input_filter #(
      .DEB   (DEB_CYCLES),
      .CNT_W (DEB_W)
    ) u_filt (
      .mclk_i   (mclk_i),
      .rst_i    (rst_i),
      .clr_i    (bcast),
      .raw_i    (st.s2.bin[i]),
      .stable_o (filt[i])
    );
  end

  // inputs as the host sees them
  // test mode swaps in the switch states so real inputs cannot trip
  always_comb begin
    rep_in = st.test_mode ? st.tin : filt;
  end

  // bus request decode and read multiplexer
  // the multiplexer is sampled into a flip-flop on the taken edge
  always_comb begin
    req   = wb_cyc_i && wb_stb_i && selected;
    wr_ok = wb_we_i && wb_sel_i[0];
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      ccd_pkg::REG_CTRL: begin
        rd_mux[ccd_pkg::CTRL_TEST_BIT] = st.test_mode;
      end
      ccd_pkg::REG_CMD: begin
        rd_mux[N-1:0] = st.cmd;
      end
      ccd_pkg::REG_INPUT: begin
        rd_mux[N-1:0] = rep_in;
        rd_mux[ccd_pkg::INPUT_STRAP_BIT] = st.strap;
        rd_mux[ccd_pkg::INPUT_GEN_BIT]   = st.s2.host_generation_switch;
      end
      ccd_pkg::REG_STAT: begin
        rd_mux[N-1:0] = st.stat;
      end
      ccd_pkg::REG_MASK: begin
        rd_mux[N-1:0] = st.mask;
      end
      ccd_pkg::REG_SIG: begin
        rd_mux[7:0] = st.sig;
      end
      // unmapped addresses read zero
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // next state of the whole controller
  // later sections override earlier ones; the broadcast reset is last
  always_comb begin
    next_st = st;
    // two-stage synchroniser for every pin
    next_st.s1 = pins;
    next_st.s2 = st.s1;

    // count edges until both sync stages hold real pin values
    if (st.fill != SYNC_FILL) begin
      next_st.fill = st.fill + 2'h1;
    end

    // catch the strap once the sync stages are filled; earlier the
    // second stage still shows its reset value instead of the pin
    if (!st.strap_ok && st.fill == SYNC_FILL) begin
      next_st.strap    = st.s2.strap;
      next_st.strap_ok = 1'b1;
    end

    // bus answer: ack one cycle, then drop
    // a request still standing in the ack cycle is not taken twice
    next_st.drive = 1'b0;
    unique case (st.bus)
      ccd_pkg::BUS_IDLE: begin
        if (req) begin
          next_st.bus   = ccd_pkg::BUS_ACK;
          next_st.rdata = rd_mux;
          next_st.drive = !wb_we_i;
        end
      end
      ccd_pkg::BUS_ACK: begin
        next_st.bus = ccd_pkg::BUS_IDLE;
      end
    endcase

    // register writes take effect with the ack
    // a write with byte lane 0 off is acked but changes nothing
    // host writes command data
    if (st.bus == ccd_pkg::BUS_IDLE && req && wr_ok) begin
      unique case (wb_adr_i)
        ccd_pkg::REG_CTRL: begin
          next_st.test_mode = wb_dat_i[ccd_pkg::CTRL_TEST_BIT];
        end
        ccd_pkg::REG_CMD: begin
          next_st.cmd = wb_dat_i[N-1:0];
        end
        ccd_pkg::REG_MASK: begin
          next_st.mask = wb_dat_i[N-1:0];
        end
        ccd_pkg::REG_SIG: begin
          next_st.sig = wb_dat_i[7:0];
        end
        // other offsets are read only or unmapped
        default: begin
          next_st.mask = st.mask;
        end
      endcase
    end

    // test input handling
    // a switch left on at entry stays off until it is cycled
    if (!st.test_mode) begin
      next_st.tin      = '0;
      next_st.seen_off = '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (!st.s2.test_input_switches[i]) begin
          next_st.seen_off[i] = 1'b1;
          next_st.tin[i]      = 1'b0;
        end else if (st.seen_off[i]) begin
          next_st.tin[i] = 1'b1;
        end
      end
    end

    // change detection; a new event wins over the read clear
    // both directions of a change count as events
    next_st.prev_in = rep_in;
    if (st.bus == ccd_pkg::BUS_IDLE && req && !wb_we_i
        && wb_adr_i == ccd_pkg::REG_STAT) begin
      next_st.stat = '0;
    end
    next_st.stat = next_st.stat | (rep_in ^ st.prev_in);
    next_st.irq  = |(next_st.stat & st.mask);

    // relay drive
    // relays lag the register by one edge, the supply pin by three
    // no coil supply, no relay
    if (!st.s2.relay_coil_supply) begin
      next_st.relay = 8'h00;
    end else if (st.strap) begin
      next_st.relay = st.sig;
    end else begin
      next_st.relay = {4'h0, st.cmd};
    end
    next_st.green = rep_in;

    // broadcast reset of card state
    // applies for as long as the code stands, over all else above
    // the filters clear through their own input
    if (bcast) begin
      next_st.test_mode = 1'b0;
      next_st.cmd       = ccd_pkg::CMD_RST;
      next_st.sig       = ccd_pkg::SIG_RST;
      next_st.mask      = ccd_pkg::MASK_RST;
      next_st.stat      = '0;
      next_st.irq       = 1'b0;
      next_st.relay     = 8'h00;
      next_st.prev_in   = '0;
    end
  end

  // state register, constants only under reset
  // the sync stages restart empty, hence the fill counter
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st      <= '0;
      st.cmd  <= ccd_pkg::CMD_RST;
      st.mask <= ccd_pkg::MASK_RST;
      st.sig  <= ccd_pkg::SIG_RST;
      st.bus  <= ccd_pkg::BUS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  // every output but card_selected_o is a flop or a small mux of flops; card_selected_o is decoded from flops
  always_comb begin
    wb_ack_o        = (st.bus == ccd_pkg::BUS_ACK);
    wb_dat_o        = st.rdata;
    data_oe_n_o     = !st.drive;
    irq_o           = st.irq;
    relay_o         = st.relay;
    // red per active output
    // a signaling card shows its output relays in the upper half
    if (st.strap) begin
      red_led_o     = st.relay[7:4];
    end else begin
      red_led_o     = st.relay[3:0];
    end
    green_led_o     = st.green;
    test_led_o      = st.test_mode;
    // closed switch means legacy host
    // reported only; the logic behaves the same for both hosts
    legacy_host_o   = st.s2.host_generation_switch;
    card_selected_o = selected;
  end

endmodule : ccd_card_controller

// ### bench/ccd_card_controller_assertions.sv
// ccd_card_controller_assertions: port checks of the command card.
// assumes a bind to ccd_card_controller, one clock, async high reset.
`timescale 1ns/1ps
module ccd_card_controller_assertions (
  input wire logic               mclk_i,
  input wire logic               rst_i,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic               wb_ack_o,
  input wire logic               data_oe_n_o,
  input wire ccd_pkg::ccd_slot_t slot_i,
  input wire logic [2:0]         address_dip_switch_i,
  input wire logic               variant_strap_i,
  input wire logic               relay_coil_supply_i,
  input wire logic               irq_o,
  input wire logic [7:0]         relay_o,
  input wire logic [3:0]         red_led_o,
  input wire logic               test_led_o,
  input wire logic               legacy_host_o,
  input wire logic               card_selected_o
);
  logic [1:0] up;  // edges since reset release, stops at three

  // strobe low and host code one above the switch number
  function automatic logic sel_f(input logic [2:0] s, input logic [1:0] sw);
    return !s[2] && (s[1:0] == sw + 2'h1);
  endfunction : sel_f

  // pin synchronisers need two edges before comparisons hold
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i) && $past(card_selected_o))
    else $error("ack without selected request");
  chk_ack_time: assert property (wb_cyc_i && wb_stb_i && card_selected_o && !wb_ack_o |=> wb_ack_o)
    else $error("selected request not acked next cycle");
  chk_oe_read: assert property (!data_oe_n_o == (wb_ack_o && !$past(wb_we_i)))
    else $error("data enable outside read ack");
  chk_slot_match: assert property (up == 2'h3 |->
    card_selected_o == sel_f($past(slot_i, 2), $past(address_dip_switch_i[1:0], 2)))
    else $error("select does not follow slot code");
  chk_host_gen: assert property (up == 2'h3 |-> legacy_host_o == $past(address_dip_switch_i[2], 2))
    else $error("host generation wrong");
  chk_coil_off: assert property (!relay_coil_supply_i [*4] |=> relay_o == 8'h00)
    else $error("relay on without coil supply");
  chk_bcast_clr: assert property (slot_i == 3'h4 [*5] |=> relay_o == 8'h00 && !irq_o && !test_led_o)
    else $error("broadcast reset left state");
  chk_red_leds: assert property (up == 2'h3 |-> red_led_o == (variant_strap_i ? relay_o[7:4] : relay_o[3:0]))
    else $error("red leds differ from relays");
endmodule : ccd_card_controller_assertions

bind ccd_card_controller ccd_card_controller_assertions i_ccd_card_controller_assertions (
  .mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o), .data_oe_n_o(data_oe_n_o), .slot_i(slot_i), .address_dip_switch_i(address_dip_switch_i),
  .variant_strap_i(variant_strap_i), .relay_coil_supply_i(relay_coil_supply_i), .irq_o(irq_o),
  .relay_o(relay_o), .red_led_o(red_led_o), .test_led_o(test_led_o), .legacy_host_o(legacy_host_o),
  .card_selected_o(card_selected_o)
);

// ### bench/ccd_host_model.sv
// ccd_host_model: host side of the card bus, Wishbone master and slot lines.
// assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps
module ccd_host_model (
  input  wire logic               mclk_i,
  input  wire logic               ack_i,
  input  wire logic [31:0]        dat_i,
  output logic                    cyc_o,
  output logic                    stb_o,
  output logic                    we_o,
  output logic      [7:0]         adr_o,
  output logic      [3:0]         sel_o,
  output logic      [31:0]        dat_o,
  output ccd_pkg::ccd_slot_t      slot_o,
  output logic                    supply_o
);
  // idle bus, slot one addressed, coil supply on
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'hF;
    dat_o = 32'h0;
    slot_o = 3'h1;
    supply_o = 1'b1;
  end

  // one classic cycle; waits for ack at most ten edges
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic ok);
    int n;
    n = 0;
    @(posedge mclk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= we;
    adr_o <= a;
    dat_o <= d;
    do begin
      @(posedge mclk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 10);
    ok = (ack_i === 1'b1);
    rd = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // released data lines do not keep the last word
    dat_o <= ~d;
  endtask : xfer

  task automatic put_slot(input logic [2:0] v);
    @(posedge mclk_i);
    slot_o <= v;
    repeat (4) @(posedge mclk_i);
  endtask : put_slot

  task automatic coil(input logic v);
    @(posedge mclk_i);
    supply_o <= v;
    repeat (4) @(posedge mclk_i);
  endtask : coil
endmodule : ccd_host_model

// ### bench/ccd_card_controller_test.sv
// ccd_card_controller_test: self-checking bench of the command card.
// assumes the host model on the bus side and a filter time of 8 cycles.
`timescale 1ns/1ps
module ccd_card_controller_test;
  localparam int DEB = 8;  // shortened input filter
  logic               mclk_i, rst_i, cyc, stb, we, ack, oe_n, supply, strap, irq, tled, legacy, sel, ok;
  logic [7:0]         adr, relay;
  logic [3:0]         sel_b, tsw, bin, red, green;
  logic [31:0]        wdat, rdat_o, rdat, v;
  logic [2:0]         dip;
  ccd_pkg::ccd_slot_t slot;
  int                 n_mismatch, samples_checked, seed;

  ccd_card_controller #(.DEB_CYCLES(DEB)) i_ccd_card_controller (
    .mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel_b), .wb_dat_i(wdat), .wb_dat_o(rdat_o), .wb_ack_o(ack), .data_oe_n_o(oe_n),
    .slot_i(slot), .address_dip_switch_i(dip), .test_input_switches_i(tsw), .bin_i(bin),
    .variant_strap_i(strap), .relay_coil_supply_i(supply), .irq_o(irq), .relay_o(relay),
    .red_led_o(red), .green_led_o(green), .test_led_o(tled), .legacy_host_o(legacy), .card_selected_o(sel));
  ccd_host_model i_ccd_host_model (
    .mclk_i(mclk_i), .ack_i(ack), .dat_i(rdat_o), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel_b), .dat_o(wdat), .slot_o(slot), .supply_o(supply));

  // expected select: host code one above the switch number
  function automatic logic hit(input logic [1:0] code, input logic [1:0] sw);
    return code == sw + 2'h1;
  endfunction : hit

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  // bus cycle; a missing ack that was due ends the run
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic acc);
    i_ccd_host_model.xfer(w, a, d, rdat, ok);
    check("ack", ok, acc);
    if (!ok && acc) final_report();
  endtask : bus

  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : wait_n

  // 25 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // hang guard
  initial begin
    wait_n(20000);
    n_mismatch++;
    final_report();
  end

  initial begin
    seed = 99267;
    rst_i = 1'b1;
    dip = 3'h0;
    tsw = 4'h0;
    bin = 4'h0;
    strap = 1'b0;
    wait_n(16);
    rst_i <= 1'b0;
    // every switch setting against every host code
    for (int s = 0; s < 4; s++) begin
      for (int h = 0; h < 4; h++) begin
        dip <= {h[0], s[1:0]};
        i_ccd_host_model.put_slot({1'b0, h[1:0]});
        check("sel", sel, hit(h[1:0], s[1:0]));
        check("legacy", legacy, h[0]);
        bus(1'b0, ccd_pkg::REG_INPUT, 32'h0, hit(h[1:0], s[1:0]));
        if (ok) check("input", rdat, {26'h0, h[0], 1'b0, 4'h0});
      end
    end
    dip <= 3'h0;
    i_ccd_host_model.put_slot(3'h1);
    // random command words, read back
    repeat (4) begin
      v = $random(seed);
      bus(1'b1, ccd_pkg::REG_CMD, v, 1'b1);
      wait_n(4);
      check("relay", relay, {4'h0, v[3:0]});
      check("red", red, v[3:0]);
      bus(1'b0, ccd_pkg::REG_CMD, 32'h0, 1'b1);
      check("cmd", rdat, {28'h0, v[3:0]});
    end
    bus(1'b0, 8'h20, 32'h0, 1'b1);
    check("unmapped", rdat, 32'h0);
    bus(1'b1, ccd_pkg::REG_CMD, 32'hF, 1'b1);
    i_ccd_host_model.coil(1'b0);
    check("coil off", relay, 8'h00);
    i_ccd_host_model.coil(1'b1);
    check("coil on", relay, 8'h0F);
    // input change, short glitch, mask and sticky status
    bus(1'b1, ccd_pkg::REG_MASK, 32'hF, 1'b1);
    v = $random(seed);
    v[0] = 1'b1;
    bin <= v[3:0];
    wait_n(3);
    check("early irq", irq, 1'b0);
    wait_n(DEB + 6);
    check("irq", irq, 1'b1);
    check("green", green, v[3:0]);
    bus(1'b0, ccd_pkg::REG_STAT, 32'h0, 1'b1);
    check("stat", rdat, {28'h0, v[3:0]});
    wait_n(3);
    check("irq clear", irq, 1'b0);
    bin <= ~v[3:0];
    wait_n(4);
    bin <= v[3:0];
    wait_n(DEB + 6);
    check("glitch", irq, 1'b0);
    bus(1'b1, ccd_pkg::REG_MASK, 32'h0, 1'b1);
    bin <= 4'h0;
    wait_n(DEB + 6);
    check("masked", irq, 1'b0);
    bus(1'b1, ccd_pkg::REG_MASK, 32'hF, 1'b1);
    wait_n(3);
    check("unmask", irq, 1'b1);
    bus(1'b0, ccd_pkg::REG_STAT, 32'h0, 1'b1);
    check("stat2", rdat, {28'h0, v[3:0]});
    // test mode: real inputs ignored, switch must go off then on
    bin <= 4'hF;
    tsw <= 4'h3;
    wait_n(DEB + 6);
    bus(1'b1, ccd_pkg::REG_CTRL, 32'h1, 1'b1);
    wait_n(DEB + 6);
    check("test entry", green, 4'h0);
    check("test led", tled, 1'b1);
    tsw <= 4'h1;
    wait_n(4);
    tsw <= 4'h3;
    wait_n(DEB + 6);
    check("test rise", green, 4'h2);
    // broadcast reset clears relays and control
    i_ccd_host_model.put_slot(3'h4);
    wait_n(4);
    i_ccd_host_model.put_slot(3'h1);
    check("bcast relay", relay, 8'h00);
    bus(1'b0, ccd_pkg::REG_CTRL, 32'h0, 1'b1);
    check("bcast ctrl", rdat, 32'h0);
    // signaling card after a second reset
    rst_i <= 1'b1;
    strap <= 1'b1;
    wait_n(2);
    rst_i <= 1'b0;
    wait_n(4);
    v = $random(seed);
    bus(1'b1, ccd_pkg::REG_SIG, v, 1'b1);
    wait_n(4);
    check("sig relay", relay, v[7:0]);
    check("sig red", red, v[7:4]);
    bus(1'b0, ccd_pkg::REG_INPUT, 32'h0, 1'b1);
    check("strap", rdat[4], 1'b1);
    final_report();
  end
endmodule : ccd_card_controller_test
